// [pkg/cbcc_pkg.sv]
// Constants and types for the bus cycle capture block
package cbcc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int ADDR_HI_W = 30;
  localparam int STAT_W = 4;
  localparam int BE_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int ENTRY_W = ADDR_HI_W + STAT_W + DATA_W + 2 + 1;
  // Entry field positions
  localparam int E_BUS_SIZE_HALF = 0;
  localparam int E_A10 = 1;
  localparam int E_DATA = 3;
  localparam int E_STAT = E_DATA + DATA_W;
  localparam int E_ADDR = E_STAT + STAT_W;
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CAP_DELAY_PS = 8000;
  localparam int CAP_DELAY_CYC = (CAP_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CYC = 2;
  localparam int CNT_W = 2;
  // Reset and phase reference values
  localparam logic PHASE_RST = 1'b0;
  localparam logic PHASE_AFTER_REF = 1'b0;
  typedef enum {C_IDLE, C_BUSY, C_PIPE} cbcc_cyc_type;
  typedef enum {O_IDLE, O_WAIT, O_PULSE} cbcc_out_type;
endpackage : cbcc_pkg

// [hw/cbcc_top.sv]
// Bus cycle capture logic and its entry FIFO
module cbcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic do_wr, do_rd;
  assign in_ready = (cnt_ff != DEPTH[PW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  always_comb begin
    nxt_wr = do_wr ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = do_rd ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_rd};
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
    if (do_wr) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule : cbcc_fifo

module cbcc_top #(
  parameter int DEPTH = cbcc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic addr_strobe_n,
  input wire logic cycle_ready_n,
  input wire logic [cbcc_pkg::BE_W-1:0] byte_enables_n,
  input wire logic [cbcc_pkg::ADDR_HI_W-1:0] addr_in,
  input wire logic [cbcc_pkg::STAT_W-1:0] status_in,
  input wire logic [cbcc_pkg::DATA_W-1:0] data_in,
  input wire logic bus_size_half_n,
  input wire logic hold_acknowledge,
  input wire logic hold_gate_jumper,
  input wire logic phase_ref,
  input wire logic analyzer_ready,
  output logic [cbcc_pkg::ADDR_HI_W-1:0] addr_out_ff,
  output logic synth_addr_bit0_ff,
  output logic synth_addr_bit1_ff,
  output logic [cbcc_pkg::STAT_W-1:0] status_out_ff,
  output logic [cbcc_pkg::DATA_W-1:0] data_out_ff,
  output logic bus_size_half_ff,
  output logic clk_j_ff,
  output logic clk_k_ff,
  output logic overflow_ff
);
  import cbcc_pkg::*;

  // Pin synchronisers
  localparam int IN_W = ADDR_HI_W + STAT_W + DATA_W + BE_W + 7;
  logic [IN_W-1:0] raw, s1_ff, s2_ff, s3_ff, stab_ff, nxt_stab;
  assign raw = {analyzer_ready, phase_ref, hold_gate_jumper, hold_acknowledge, bus_size_half_n,
                cycle_ready_n, addr_strobe_n, byte_enables_n, status_in, addr_in, data_in};
  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_sync
      always_comb begin
        nxt_stab[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : stab_ff[gi];
      end
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          s1_ff[gi] <= 1'b1;
          s2_ff[gi] <= 1'b1;
          s3_ff[gi] <= 1'b1;
          stab_ff[gi] <= 1'b1;
        end else begin
          s1_ff[gi] <= raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          stab_ff[gi] <= nxt_stab[gi];
        end
      end
    end
  endgenerate

  logic [DATA_W-1:0] data_s;
  logic [ADDR_HI_W-1:0] addr_s;
  logic [STAT_W-1:0] stat_s;
  logic [BE_W-1:0] be_n_s;
  logic strobe_n_s, ready_n_s, bus_size_half_n_s, hold_s, jumper_s, ref_s, an_rdy_s;
  assign {an_rdy_s, ref_s, jumper_s, hold_s, bus_size_half_n_s, ready_n_s, strobe_n_s,
          be_n_s, stat_s, addr_s, data_s} = stab_ff;

  logic registered_addr_strobe, registered_cycle_done;
  assign registered_addr_strobe = ~strobe_n_s;
  assign registered_cycle_done = ~ready_n_s;

  // Recreated phase clock
  logic phase_ff, nxt_phase;
  always_comb begin
    nxt_phase = ref_s ? PHASE_AFTER_REF : ~phase_ff;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_ff <= PHASE_RST;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Cycle tracking
  cbcc_cyc_type cst_ff, nxt_cst;
  logic gap_ff, nxt_gap, pipe_ff, nxt_pipe, cycle_end, cap, push, fifo_in_ready;
  logic [ADDR_HI_W-1:0] cur_addr_ff, nxt_cur_addr;
  logic [STAT_W-1:0] cur_stat_ff, nxt_cur_stat;
  logic [BE_W-1:0] cur_be_ff, nxt_cur_be;
  logic cur_bus_size_half_ff, nxt_cur_bus_size_half;
  logic [1:0] a10;
  logic [ENTRY_W-1:0] push_word;

  assign cycle_end = (cst_ff == C_BUSY) & phase_ff & registered_cycle_done;
  assign push = cycle_end;

  always_comb begin
    // Position of lowest asserted enable
    a10 = 2'b00;
    if (cur_be_ff[0]) begin
      if (!cur_be_ff[1]) begin
        a10 = 2'b01;
      end else if (!cur_be_ff[2]) begin
        a10 = 2'b10;
      end else if (!cur_be_ff[3]) begin
        a10 = 2'b11;
      end
    end
  end
  assign push_word = {cur_addr_ff, cur_stat_ff, data_s, a10, cur_bus_size_half_ff};

  always_comb begin
    nxt_cst = cst_ff;
    nxt_gap = gap_ff;
    nxt_pipe = pipe_ff;
    cap = 1'b0;
    case (cst_ff)
      C_IDLE: begin
        if (registered_addr_strobe) begin
          cap = 1'b1;
          nxt_cst = C_BUSY;
          nxt_gap = 1'b0;
          nxt_pipe = 1'b0;
        end
      end
      C_BUSY: begin
        if (!registered_addr_strobe) begin
          nxt_gap = 1'b1;
        end else if (gap_ff && phase_ff) begin
          nxt_pipe = 1'b1;
        end
        if (cycle_end) begin
          nxt_cst = (pipe_ff || (gap_ff && registered_addr_strobe)) ? C_PIPE : C_IDLE;
        end
      end
      C_PIPE: begin
        cap = 1'b1;
        nxt_cst = C_BUSY;
        nxt_gap = 1'b0;
        nxt_pipe = 1'b0;
      end
      default: begin
        nxt_cst = C_IDLE;
      end
    endcase
    nxt_cur_addr = cap ? addr_s : cur_addr_ff;
    nxt_cur_stat = cap ? stat_s : cur_stat_ff;
    nxt_cur_be = cap ? be_n_s : cur_be_ff;
    nxt_cur_bus_size_half = cap ? ~bus_size_half_n_s : cur_bus_size_half_ff;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cst_ff <= C_IDLE;
      gap_ff <= 1'b0;
      pipe_ff <= 1'b0;
      cur_addr_ff <= '0;
      cur_stat_ff <= '0;
      cur_be_ff <= '1;
      cur_bus_size_half_ff <= 1'b0;
    end else begin
      cst_ff <= nxt_cst;
      gap_ff <= nxt_gap;
      pipe_ff <= nxt_pipe;
      cur_addr_ff <= nxt_cur_addr;
      cur_stat_ff <= nxt_cur_stat;
      cur_be_ff <= nxt_cur_be;
      cur_bus_size_half_ff <= nxt_cur_bus_size_half;
    end
  end

  // Entry buffer
  logic fifo_valid, fifo_pop;
  logic [ENTRY_W-1:0] fifo_word;
  cbcc_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  // Output stage and analyzer clocks
  cbcc_out_type ost_ff, nxt_ost;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic nxt_clk, nxt_ovf, gate;
  assign gate = hold_s & jumper_s;
  assign fifo_pop = (ost_ff == O_IDLE) & fifo_valid & an_rdy_s;
  always_comb begin
    nxt_ost = ost_ff;
    nxt_cnt = cnt_ff;
    case (ost_ff)
      O_IDLE: begin
        if (fifo_pop) begin
          nxt_ost = O_WAIT;
          nxt_cnt = '0;
        end
      end
      O_WAIT: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CNT_W'(CAP_DELAY_CYC - 1)) begin
          nxt_ost = O_PULSE;
          nxt_cnt = '0;
        end
      end
      O_PULSE: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CNT_W'(PULSE_CYC - 1)) begin
          nxt_ost = O_IDLE;
        end
      end
      default: begin
        nxt_ost = O_IDLE;
      end
    endcase
    nxt_clk = (nxt_ost == O_PULSE) & ~gate;
    nxt_ovf = overflow_ff | (push & ~fifo_in_ready);
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ost_ff <= O_IDLE;
      cnt_ff <= '0;
      clk_j_ff <= 1'b0;
      clk_k_ff <= 1'b0;
      overflow_ff <= 1'b0;
      addr_out_ff <= '0;
      synth_addr_bit0_ff <= 1'b0;
      synth_addr_bit1_ff <= 1'b0;
      status_out_ff <= '0;
      data_out_ff <= '0;
      bus_size_half_ff <= 1'b0;
    end else begin
      ost_ff <= nxt_ost;
      cnt_ff <= nxt_cnt;
      clk_j_ff <= nxt_clk;
      clk_k_ff <= nxt_clk;
      overflow_ff <= nxt_ovf;
      if (fifo_pop) begin
        addr_out_ff <= fifo_word[E_ADDR +: ADDR_HI_W];
        status_out_ff <= fifo_word[E_STAT +: STAT_W];
        data_out_ff <= fifo_word[E_DATA +: DATA_W];
        synth_addr_bit0_ff <= fifo_word[E_A10];
        synth_addr_bit1_ff <= fifo_word[E_A10 + 1];
        bus_size_half_ff <= fifo_word[E_BUS_SIZE_HALF];
      end
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  clk_delay_a: assert property (fifo_pop |=> (ost_ff == O_WAIT) [*2] ##1 (ost_ff == O_PULSE))
    else $error("Analyzer clock delay wrong");
  clk_pair_a: assert property (clk_j_ff == clk_k_ff)
    else $error("Analyzer clocks differ");
  hold_gate_a: assert property (gate |=> !clk_j_ff)
    else $error("Clock not suppressed in hold");
  low_bits_a: assert property (push && !cur_be_ff[0] |-> push_word[E_A10 +: 2] == 2'b00)
    else $error("Low address bits wrong");
  high_enable_a: assert property (push && cur_be_ff == 4'h7 |-> push_word[E_A10 +: 2] == 2'b11)
    else $error("Enable three not encoded");
  end_cond_a: assert property (push |-> phase_ff && registered_cycle_done && cst_ff == C_BUSY)
    else $error("End seen off condition");
  phase_div_a: assert property (!ref_s |=> phase_ff != $past(phase_ff))
    else $error("Phase clock not halved");
  start_cap_a: assert property (cst_ff == C_IDLE && registered_addr_strobe |=> cst_ff == C_BUSY
    && cur_addr_ff == $past(addr_s))
    else $error("Start not captured");
  pipe_cap_a: assert property (cst_ff == C_PIPE |=> cst_ff == C_BUSY && cur_addr_ff == $past(addr_s))
    else $error("Pipelined address missed");
  data_cap_a: assert property (push |-> push_word[E_DATA +: DATA_W] == data_s)
    else $error("Data not captured at end");
  reset_a: assert property (disable iff (1'b0) !reset_n |=> !clk_j_ff && cst_ff == C_IDLE)
    else $error("Reset left state");
  pipe_c: cover property (cst_ff == C_PIPE);
  gated_c: cover property (ost_ff == O_PULSE && gate);
  ovf_c: cover property (push && !fifo_in_ready);
endmodule : cbcc_top

// [test/cbcc_cpu_model.sv]
// Processor bus model driving cycles into the capture block
module cbcc_cpu_model (
  input wire logic clk,
  output logic addr_strobe_n,
  output logic cycle_ready_n,
  output logic [cbcc_pkg::BE_W-1:0] byte_enables_n,
  output logic [cbcc_pkg::ADDR_HI_W-1:0] addr_in,
  output logic [cbcc_pkg::STAT_W-1:0] status_in,
  output logic [cbcc_pkg::DATA_W-1:0] data_in,
  output logic bus_size_half_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import cbcc_pkg::*;

  initial begin
    addr_strobe_n = 1'b1;
    cycle_ready_n = 1'b1;
    byte_enables_n = 4'hf;
    addr_in = '0;
    status_in = '0;
    data_in = '0;
    bus_size_half_n = 1'b1;
  end

  // One non-pipelined cycle of eight input clocks
  task automatic bus_cycle(input logic [BE_W-1:0] be, input logic [ADDR_HI_W-1:0] a,
                           input logic [STAT_W-1:0] s, input logic [DATA_W-1:0] d, input logic bs_n);
    @(negedge clk);
    addr_strobe_n = 1'b0;
    byte_enables_n = be;
    addr_in = a;
    status_in = s;
    data_in = d;
    bus_size_half_n = bs_n;
    repeat (2) @(negedge clk);
    addr_strobe_n = 1'b1;
    @(negedge clk);
    cycle_ready_n = 1'b0;
    repeat (2) @(negedge clk);
    cycle_ready_n = 1'b1;
    // Released lines stop showing the old value
    data_in = ~d;
    addr_in = ~a;
    status_in = ~s;
    byte_enables_n = ~be;
    bus_size_half_n = ~bs_n;
    repeat (2) @(negedge clk);
  endtask : bus_cycle

  // Second cycle strobed in the same clock as the first cycle's ready
  task automatic pipe_cycle(input logic [BE_W-1:0] be0, input logic [ADDR_HI_W-1:0] a0,
                            input logic [STAT_W-1:0] s0, input logic [DATA_W-1:0] d0,
                            input logic [BE_W-1:0] be1, input logic [ADDR_HI_W-1:0] a1,
                            input logic [STAT_W-1:0] s1, input logic [DATA_W-1:0] d1);
    @(negedge clk);
    addr_strobe_n = 1'b0;
    byte_enables_n = be0;
    addr_in = a0;
    status_in = s0;
    data_in = d0;
    bus_size_half_n = 1'b1;
    repeat (2) @(negedge clk);
    addr_strobe_n = 1'b1;
    @(negedge clk);
    addr_strobe_n = 1'b0;
    cycle_ready_n = 1'b0;
    byte_enables_n = be1;
    addr_in = a1;
    status_in = s1;
    repeat (2) @(negedge clk);
    addr_strobe_n = 1'b1;
    cycle_ready_n = 1'b1;
    data_in = d1;
    @(negedge clk);
    cycle_ready_n = 1'b0;
    repeat (2) @(negedge clk);
    cycle_ready_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : pipe_cycle
endmodule : cbcc_cpu_model

// [test/test_cbcc_top.sv]
// Self-checking bench for the bus cycle capture block
module test_cbcc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cbcc_pkg::*;

  typedef struct packed {
    logic [BE_W-1:0] be;
    logic [ADDR_HI_W-1:0] a;
    logic [STAT_W-1:0] s;
    logic [DATA_W-1:0] d;
    logic bs_n;
    logic [1:0] a10;
  } cbcc_row_type;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hold_acknowledge = 1'b0;
  logic hold_gate_jumper = 1'b0;
  logic phase_ref = 1'b0;
  logic analyzer_ready = 1'b1;
  logic addr_strobe_n, cycle_ready_n, bus_size_half_n;
  logic [BE_W-1:0] byte_enables_n;
  logic [ADDR_HI_W-1:0] addr_in, addr_out_ff;
  logic [STAT_W-1:0] status_in, status_out_ff;
  logic [DATA_W-1:0] data_in, data_out_ff;
  logic synth_addr_bit0_ff, synth_addr_bit1_ff, bus_size_half_ff, clk_j_ff, clk_k_ff, overflow_ff;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  bit got;
  cbcc_row_type rows [6] = '{
    '{4'he, 30'h0000_0001, 4'h1, 32'h1111_1111, 1'b1, 2'h0},
    '{4'hd, 30'h2aaa_aaaa, 4'h2, 32'hdead_beef, 1'b0, 2'h1},
    '{4'hb, 30'h1555_5555, 4'h4, 32'h0000_0000, 1'b1, 2'h2},
    '{4'h7, 30'h3fff_ffff, 4'h8, 32'hffff_ffff, 1'b0, 2'h3},
    '{4'h0, 30'h0123_4567, 4'hf, 32'h89ab_cdef, 1'b1, 2'h0},
    '{4'hf, 30'h0000_0000, 4'h0, 32'h5a5a_a5a5, 1'b1, 2'h0}};
  cbcc_row_type pipe_rows [2] = '{
    '{4'he, 30'h0000_0100, 4'h5, 32'h0a0a_0a0a, 1'b1, 2'h0},
    '{4'h7, 30'h0000_0200, 4'h6, 32'h0b0b_0b0b, 1'b1, 2'h3}};

  always #2 clk = ~clk;

  cbcc_cpu_model cpu (.clk(clk), .addr_strobe_n(addr_strobe_n), .cycle_ready_n(cycle_ready_n),
    .byte_enables_n(byte_enables_n), .addr_in(addr_in), .status_in(status_in), .data_in(data_in),
    .bus_size_half_n(bus_size_half_n));

  cbcc_top #(.DEPTH(FIFO_DEPTH)) dut (.clk(clk), .reset_n(reset_n), .addr_strobe_n(addr_strobe_n),
    .cycle_ready_n(cycle_ready_n), .byte_enables_n(byte_enables_n), .addr_in(addr_in),
    .status_in(status_in), .data_in(data_in), .bus_size_half_n(bus_size_half_n),
    .hold_acknowledge(hold_acknowledge), .hold_gate_jumper(hold_gate_jumper), .phase_ref(phase_ref),
    .analyzer_ready(analyzer_ready), .addr_out_ff(addr_out_ff), .synth_addr_bit0_ff(synth_addr_bit0_ff),
    .synth_addr_bit1_ff(synth_addr_bit1_ff), .status_out_ff(status_out_ff), .data_out_ff(data_out_ff),
    .bus_size_half_ff(bus_size_half_ff), .clk_j_ff(clk_j_ff), .clk_k_ff(clk_k_ff), .overflow_ff(overflow_ff));

  task automatic results();
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_pulse(output bit hit);
    hit = 1'b0;
    for (int i = 0; i < 40 && !hit; i++) begin
      @(negedge clk);
      hit = (clk_j_ff === 1'b1);
    end
  endtask : wait_pulse

  task automatic expect_entry(input cbcc_row_type r);
    bit hit;
    wait_pulse(hit);
    check("pulse", hit, 1'b1);
    check("clk_k", clk_k_ff, 1'b1);
    check("addr", addr_out_ff, r.a);
    check("a10", {synth_addr_bit1_ff, synth_addr_bit0_ff}, r.a10);
    check("status", status_out_ff, r.s);
    check("data", data_out_ff, r.d);
    check("bus_size_half", bus_size_half_ff, 1'(~r.bs_n));
    @(negedge clk);
    check("pulse_hi", clk_j_ff, 1'b1);
    @(negedge clk);
    check("pulse_lo", clk_j_ff, 1'b0);
  endtask : expect_entry

  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (12) @(negedge clk);
    check("rst_clk", {clk_j_ff, clk_k_ff, overflow_ff}, 3'h0);
    check("rst_data", data_out_ff, 32'h0000_0000);
    reset_n = 1'b1;
    @(negedge clk);
    phase_ref = 1'b1;
    repeat (3) @(negedge clk);
    phase_ref = 1'b0;
    wait_pulse(got);
    check("rst_quiet", got, 1'b0);
  endtask : do_reset

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      results();
    end
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      fork
        cpu.bus_cycle(rows[i].be, rows[i].a, rows[i].s, rows[i].d, rows[i].bs_n);
        expect_entry(rows[i]);
      join
    end
    fork
      cpu.pipe_cycle(pipe_rows[0].be, pipe_rows[0].a, pipe_rows[0].s, pipe_rows[0].d,
                     pipe_rows[1].be, pipe_rows[1].a, pipe_rows[1].s, pipe_rows[1].d);
      begin
        expect_entry(pipe_rows[0]);
        expect_entry(pipe_rows[1]);
      end
    join
    hold_acknowledge = 1'b1;
    hold_gate_jumper = 1'b1;
    fork
      cpu.bus_cycle(4'h0, 30'h0000_0abc, 4'h3, 32'hcafe_0001, 1'b1);
      wait_pulse(got);
    join
    check("hold_gated", got, 1'b0);
    check("hold_data", data_out_ff, 32'hcafe_0001);
    hold_gate_jumper = 1'b0;
    fork
      cpu.bus_cycle(4'h0, 30'h0000_0abd, 4'h3, 32'hcafe_0002, 1'b1);
      wait_pulse(got);
    join
    check("hold_open", got, 1'b1);
    hold_acknowledge = 1'b0;
    repeat (4) @(negedge clk);
    analyzer_ready = 1'b0;
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      cpu.bus_cycle(4'h0, 30'(i), 4'h0, 32'(i), 1'b1);
    end
    repeat (4) @(negedge clk);
    check("overflow", overflow_ff, 1'b1);
    analyzer_ready = 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      wait_pulse(got);
      check("drain_pulse", got, 1'b1);
      check("drain_data", data_out_ff, 32'(i));
      @(negedge clk);
    end
    wait_pulse(got);
    check("drain_empty", got, 1'b0);
    do_reset();
    results();
  end
endmodule : test_cbcc_top
